// file: itp_target.sv
// Two-wire serial target that writes and reads 16-bit register values
//
// Contract
// - Decode seven-bit addresses only, never ten-bit
// - Same protocol at 100k, 400k, 1M
// - General call 0x00 then 0x06 resets
// - Reset pulse at ack rise after 0x06
// - Start is SDA falling while SCL high
// - Stop releases bus, await start and address
// - Seven address bits MSB first, then direction
// - Acknowledge own, broadcast or general call address, SDA low
// - Eight bits plus receiver's acknowledge per byte
// - Receive on write, transmit register on read
// - Address, command, high, low bytes, all acked
// - Update only after both data bytes
// - Update on SCL fall ending last ack
// - Upper address bits fixed at 1001
// - Strap connection gives low three bits
// - Strap sampled in first byte, latched
// - Acknowledge broadcast 1000111 with write direction
// - Broadcast never acknowledged for read
// - Read: command write, restart, high then low
// - First seen interface type locks until power
`timescale 1ns/100ps
module itp_target (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Bus pins, open drain data
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Address strap pin
  input wire logic addr_strap_pin,
  // Interface type selection
  input wire logic spi_seen,
  output logic i2c_locked,
  // Register write port
  output logic wr_valid,
  output logic wr_broadcast,
  output logic [7:0] wr_cmd,
  output logic [15:0] wr_data,
  // Register read port
  output logic [7:0] rd_cmd,
  input wire logic [15:0] rd_data,
  // General call reset
  output logic gc_reset
);

  // ----------------------------------------------------------------
  // Pin sampling and bus conditions
  // ----------------------------------------------------------------
  logic [2:0] pin_sync;
  logic scl_s;
  logic sda_s;
  logic strap_s;
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  itp_sync u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .pin_in({addr_strap_pin, sda_in, scl_in}),
    .pin_sync(pin_sync)
  );

  assign scl_s = pin_sync[0];
  assign sda_s = pin_sync[1];
  assign strap_s = pin_sync[2];

  // Sampling at 4 ns resolves every bus speed alike
  always_ff @(posedge core_clk) begin
    if (rst) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_prev_q;
  assign scl_fall = !scl_s && scl_prev_q;
  // SDA may only move under low SCL, so any move under high SCL
  // is a bus condition
  assign start_det = scl_s && scl_prev_q && sda_prev_q && !sda_s;
  assign stop_det = scl_s && scl_prev_q && !sda_prev_q && sda_s;

  // ----------------------------------------------------------------
  // Interface type lock
  // ----------------------------------------------------------------
  itp_pkg::itp_mode_t mode_q;
  logic bus_start;
  logic bus_stop;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_q <= itp_pkg::ITP_MODE_NONE;
    end else if (mode_q == itp_pkg::ITP_MODE_NONE) begin
      if (start_det) begin
        mode_q <= itp_pkg::ITP_MODE_I2C;
      end else if (spi_seen) begin
        mode_q <= itp_pkg::ITP_MODE_SPI;
      end
    end
  end

  assign bus_start = start_det && (mode_q != itp_pkg::ITP_MODE_SPI);
  assign bus_stop = stop_det && (mode_q != itp_pkg::ITP_MODE_SPI);
  assign i2c_locked = (mode_q == itp_pkg::ITP_MODE_I2C);

  // ----------------------------------------------------------------
  // Address strap
  // ----------------------------------------------------------------
  itp_pkg::itp_state_t state_q;
  logic [1:0] idx_q;
  logic [2:0] strap_code;
  logic first_byte;

  assign first_byte = (state_q == itp_pkg::ITP_ST_RX) &&
                      (idx_q == itp_pkg::IDX_ADDR);

  itp_strap u_strap (
    .core_clk(core_clk),
    .rst(rst),
    .frame_start(bus_start),
    .first_byte(first_byte),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .scl_lvl(scl_s),
    .sda_lvl(sda_s),
    .strap_lvl(strap_s),
    .strap_code(strap_code)
  );

  // ----------------------------------------------------------------
  // Address classification
  // ----------------------------------------------------------------
  function automatic itp_pkg::itp_hit_t addr_class(
    input logic [7:0] abyte,
    input logic [2:0] strap
  );
    itp_pkg::itp_hit_t hit;
    hit = itp_pkg::ITP_HIT_NONE;
    // Ten-bit headers never fall in the 1001 group
    if (abyte[7:1] == {itp_pkg::TGT_ADDR_HI, strap}) begin
      hit = itp_pkg::ITP_HIT_OWN;
    end else if (abyte == {itp_pkg::BCAST_ADDR, itp_pkg::RW_WRITE}) begin
      hit = itp_pkg::ITP_HIT_BCAST;
    end else if (abyte == {itp_pkg::GCALL_ADDR, itp_pkg::RW_WRITE}) begin
      hit = itp_pkg::ITP_HIT_GCALL;
    end
    return hit;
  endfunction

  // ----------------------------------------------------------------
  // Byte engine
  // ----------------------------------------------------------------
  logic [3:0] bit_q;
  logic [7:0] shift_q;
  logic [15:0] tx_q;
  logic rw_q;
  logic bcast_q;
  logic gcall_q;
  logic tx_low_q;
  logic host_ack_q;
  logic sda_oe_q;
  logic rx_done;
  logic ack_rise;
  logic ack_fall;
  itp_pkg::itp_hit_t hit;

  assign rx_done = (state_q == itp_pkg::ITP_ST_RX) && scl_fall &&
                   (bit_q == itp_pkg::RX_LAST_BIT);
  assign ack_rise = (state_q == itp_pkg::ITP_ST_ACK) && scl_rise;
  assign ack_fall = (state_q == itp_pkg::ITP_ST_ACK) && scl_fall;
  assign hit = addr_class(shift_q, strap_code);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= itp_pkg::ITP_ST_IDLE;
      bit_q <= itp_pkg::BIT_CNT_RST;
      idx_q <= itp_pkg::IDX_ADDR;
      shift_q <= itp_pkg::BYTE_RST;
      tx_q <= itp_pkg::WORD_RST;
      rw_q <= itp_pkg::RW_WRITE;
      bcast_q <= 1'b0;
      gcall_q <= 1'b0;
      tx_low_q <= 1'b0;
      host_ack_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (bus_start) begin
      // A restart goes back to the address byte; the captured command stays for the read
      state_q <= itp_pkg::ITP_ST_RX;
      bit_q <= itp_pkg::BIT_CNT_RST;
      idx_q <= itp_pkg::IDX_ADDR;
      sda_oe_q <= 1'b0;
    end else if (bus_stop) begin
      state_q <= itp_pkg::ITP_ST_IDLE;
      sda_oe_q <= 1'b0;
    end else begin
      case (state_q)
        itp_pkg::ITP_ST_RX: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_s};
            bit_q <= bit_q + 4'h1;
          end else if (rx_done) begin
            if (idx_q == itp_pkg::IDX_ADDR) begin
              rw_q <= shift_q[0];
              bcast_q <= (hit == itp_pkg::ITP_HIT_BCAST);
              gcall_q <= (hit == itp_pkg::ITP_HIT_GCALL);
              if (hit != itp_pkg::ITP_HIT_NONE) begin
                state_q <= itp_pkg::ITP_ST_ACK;
                sda_oe_q <= 1'b1;
              end else begin
                state_q <= itp_pkg::ITP_ST_WAIT;
              end
            end else if (gcall_q &&
                         shift_q != itp_pkg::GCALL_RESET_BYTE) begin
              state_q <= itp_pkg::ITP_ST_WAIT;
            end else begin
              state_q <= itp_pkg::ITP_ST_ACK;
              sda_oe_q <= 1'b1;
            end
          end
        end
        itp_pkg::ITP_ST_ACK: begin
          if (ack_fall) begin
            sda_oe_q <= 1'b0;
            bit_q <= itp_pkg::BIT_CNT_RST;
            if (idx_q == itp_pkg::IDX_ADDR && rw_q == itp_pkg::RW_READ) begin
              // High byte first goes out as soon as SCL is low
              state_q <= itp_pkg::ITP_ST_TX;
              tx_q <= rd_data;
              tx_low_q <= 1'b0;
              sda_oe_q <= !rd_data[15];
            end else if (gcall_q && idx_q == itp_pkg::IDX_CMD) begin
              state_q <= itp_pkg::ITP_ST_WAIT;
            end else begin
              state_q <= itp_pkg::ITP_ST_RX;
              // Further byte pairs are further updates
              if (idx_q == itp_pkg::IDX_LOW) begin
                idx_q <= itp_pkg::IDX_HIGH;
              end else begin
                idx_q <= idx_q + 2'h1;
              end
            end
          end
        end
        itp_pkg::ITP_ST_TX: begin
          if (scl_fall) begin
            tx_q <= {tx_q[14:0], 1'b0};
            bit_q <= bit_q + 4'h1;
            // Data moves only while SCL is low
            if (bit_q == itp_pkg::TX_LAST_BIT) begin
              state_q <= itp_pkg::ITP_ST_TXACK;
              sda_oe_q <= 1'b0;
            end else begin
              sda_oe_q <= !tx_q[14];
            end
          end
        end
        itp_pkg::ITP_ST_TXACK: begin
          if (scl_rise) begin
            host_ack_q <= !sda_s;
          end else if (scl_fall) begin
            bit_q <= itp_pkg::BIT_CNT_RST;
            if (host_ack_q && !tx_low_q) begin
              state_q <= itp_pkg::ITP_ST_TX;
              tx_low_q <= 1'b1;
              sda_oe_q <= !tx_q[15];
            end else begin
              state_q <= itp_pkg::ITP_ST_WAIT;
            end
          end
        end
        itp_pkg::ITP_ST_IDLE,
        itp_pkg::ITP_ST_WAIT: begin
          sda_oe_q <= 1'b0;
        end
        default: begin
          state_q <= itp_pkg::ITP_ST_IDLE;
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Command and data capture
  // ----------------------------------------------------------------
  logic [7:0] cmd_q;
  logic [7:0] high_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmd_q <= itp_pkg::BYTE_RST;
      high_q <= itp_pkg::BYTE_RST;
    end else if (rx_done && !gcall_q) begin
      if (idx_q == itp_pkg::IDX_CMD) begin
        cmd_q <= shift_q;
      end else if (idx_q == itp_pkg::IDX_HIGH) begin
        high_q <= shift_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Update and reset strobes
  // ----------------------------------------------------------------
  logic wr_valid_q;
  logic wr_bcast_q;
  logic [7:0] wr_cmd_q;
  logic [15:0] wr_data_q;
  logic gc_reset_q;
  logic do_update;

  assign do_update = ack_fall && !gcall_q && rw_q == itp_pkg::RW_WRITE &&
                     idx_q == itp_pkg::IDX_LOW;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_valid_q <= 1'b0;
      wr_bcast_q <= 1'b0;
      wr_cmd_q <= itp_pkg::BYTE_RST;
      wr_data_q <= itp_pkg::WORD_RST;
    end else begin
      wr_valid_q <= do_update;
      if (do_update) begin
        wr_bcast_q <= bcast_q;
        wr_cmd_q <= cmd_q;
        wr_data_q <= {high_q, shift_q};
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      gc_reset_q <= 1'b0;
    end else begin
      gc_reset_q <= ack_rise && gcall_q && idx_q == itp_pkg::IDX_CMD;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_q;
  assign wr_valid = wr_valid_q;
  assign wr_broadcast = wr_bcast_q;
  assign wr_cmd = wr_cmd_q;
  assign wr_data = wr_data_q;
  assign rd_cmd = cmd_q;
  assign gc_reset = gc_reset_q;

endmodule

// file: itp_pkg.sv
// Shared constants and types of the two-wire target register port
package itp_pkg;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  localparam logic [3:0] TGT_ADDR_HI = 4'h9;
  localparam logic [6:0] BCAST_ADDR = 7'h47;
  localparam logic [6:0] GCALL_ADDR = 7'h00;
  localparam logic [7:0] GCALL_RESET_BYTE = 8'h06;
  localparam logic RW_WRITE = 1'h0;
  localparam logic RW_READ = 1'h1;

  // ----------------------------------------------------------------
  // Strap connection codes
  // ----------------------------------------------------------------
  localparam logic [2:0] STRAP_GND = 3'h0;
  localparam logic [2:0] STRAP_VDD = 3'h1;
  localparam logic [2:0] STRAP_SDA = 3'h2;
  localparam logic [2:0] STRAP_SCL = 3'h3;

  // ----------------------------------------------------------------
  // Byte framing
  // ----------------------------------------------------------------
  localparam logic [3:0] BIT_CNT_RST = 4'h0;
  localparam logic [3:0] RX_LAST_BIT = 4'h8;
  localparam logic [3:0] TX_LAST_BIT = 4'h7;
  localparam logic [1:0] IDX_ADDR = 2'h0;
  localparam logic [1:0] IDX_CMD = 2'h1;
  localparam logic [1:0] IDX_HIGH = 2'h2;
  localparam logic [1:0] IDX_LOW = 2'h3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [2:0] SYNC_RST = 3'h7;

  // ----------------------------------------------------------------
  // Address classes, byte engine states and interface modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ITP_HIT_NONE,
    ITP_HIT_OWN,
    ITP_HIT_BCAST,
    ITP_HIT_GCALL
  } itp_hit_t;

  typedef enum {
    ITP_ST_IDLE,
    ITP_ST_RX,
    ITP_ST_ACK,
    ITP_ST_TX,
    ITP_ST_TXACK,
    ITP_ST_WAIT
  } itp_state_t;

  typedef enum {
    ITP_MODE_NONE,
    ITP_MODE_I2C,
    ITP_MODE_SPI
  } itp_mode_t;

endpackage

// file: itp_sync.sv
// Two-stage synchroniser for the serial clock, data and strap pins
`timescale 1ns/100ps
module itp_sync (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Asynchronous pins
  input wire logic [2:0] pin_in,
  // Synchronised levels
  output logic [2:0] pin_sync
);

  logic [2:0] meta_q;
  logic [2:0] sync_q;

  // Idle bus lines are pulled high, so reset to high
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_q <= itp_pkg::SYNC_RST;
      sync_q <= itp_pkg::SYNC_RST;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  assign pin_sync = sync_q;

endmodule

// file: itp_strap.sv
// Strap pin connection detector for the low target address bits
`timescale 1ns/100ps
module itp_strap (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Frame control
  input wire logic frame_start,
  input wire logic first_byte,
  // Bus events and levels
  input wire logic scl_rise,
  input wire logic scl_fall,
  input wire logic scl_lvl,
  input wire logic sda_lvl,
  input wire logic strap_lvl,
  // Decoded low address bits
  output logic [2:0] strap_code
);

  logic seen_low_q;
  logic seen_high_q;
  logic diff_scl_q;
  logic diff_sda_q;
  logic [2:0] code_q;

  // Watch the strap against both bus lines through the first byte
  always_ff @(posedge core_clk) begin
    if (rst || frame_start) begin
      seen_low_q <= 1'b0;
      seen_high_q <= 1'b0;
      diff_scl_q <= 1'b0;
      diff_sda_q <= 1'b0;
    end else if (first_byte && (scl_rise || scl_fall)) begin
      if (strap_lvl) begin
        seen_high_q <= 1'b1;
      end else begin
        seen_low_q <= 1'b1;
      end
      if (strap_lvl != scl_lvl) begin
        diff_scl_q <= 1'b1;
      end
      if (scl_rise && (strap_lvl != sda_lvl)) begin
        diff_sda_q <= 1'b1;
      end
    end
  end

  // Flags freeze after the first byte, so the code stays latched
  always_ff @(posedge core_clk) begin
    if (rst) begin
      code_q <= itp_pkg::STRAP_GND;
    end else if (!seen_high_q) begin
      code_q <= itp_pkg::STRAP_GND;
    end else if (!seen_low_q) begin
      code_q <= itp_pkg::STRAP_VDD;
    end else if (!diff_scl_q) begin
      code_q <= itp_pkg::STRAP_SCL;
    end else begin
      code_q <= itp_pkg::STRAP_SDA;
    end
  end

  assign strap_code = code_q;

endmodule

// file: itp_target_props.sv
// Concurrent checks on the two-wire target register port
`timescale 1ns/100ps
module itp_target_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic addr_strap_pin,
  // Interface type
  input wire logic spi_seen,
  input wire logic i2c_locked,
  // Register ports
  input wire logic wr_valid,
  input wire logic wr_broadcast,
  input wire logic [7:0] wr_cmd,
  input wire logic [15:0] wr_data,
  input wire logic [7:0] rd_cmd,
  input wire logic [15:0] rd_data,
  input wire logic gc_reset
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [3:0] lo_q;
  logic [3:0] hi_q;
  // ----------------------------------------------------------------
  // Cycles spent in the present SCL level
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst || scl_in) lo_q <= 4'h0;
    else if (lo_q != 4'hf) lo_q <= lo_q + 4'h1;
  end
  always_ff @(posedge core_clk) begin
    if (rst || !scl_in) hi_q <= 4'h0;
    else if (hi_q != 4'hf) hi_q <= hi_q + 4'h1;
  end
  sequence s_stop;
    scl_in && $rose(sda_in);
  endsequence
  sequence s_quiet;
    (!wr_valid && !sda_oe)[*8];
  endsequence
  AST_OUT_ZERO: assert property (sda_out == 1'h0)
    else $error("sda_out not held low");
  AST_OE_LOCK: assert property (!i2c_locked |-> !sda_oe)
    else $error("SDA driven before interface lock");
  AST_LOCK_HOLD: assert property (i2c_locked |=> i2c_locked)
    else $error("interface lock dropped");
  AST_OE_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("SDA drive changed while SCL high");
  AST_ACK_STANDS: assert property (sda_oe && scl_in |=> sda_oe)
    else $error("SDA drive released during SCL high");
  AST_WR_AT_FALL: assert property (wr_valid |-> !scl_in &&
    lo_q inside {[2:7]} ##1 !wr_valid)
    else $error("update strobe not one cycle after SCL fall");
  AST_GC_AT_RISE: assert property (gc_reset |-> scl_in &&
    hi_q inside {[2:7]} ##1 !gc_reset)
    else $error("general call reset not one cycle after SCL rise");
  AST_DATA_HOLD: assert property
    ($changed(wr_data) || $changed(wr_cmd) |-> wr_valid)
    else $error("update outputs changed without strobe");
  AST_STOP_QUIET: assert property (s_stop |-> ##1 s_quiet)
    else $error("activity right after stop");
endmodule
bind itp_target itp_target_chk u_chk (.core_clk(core_clk), .rst(rst),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .addr_strap_pin(addr_strap_pin), .spi_seen(spi_seen),
  .i2c_locked(i2c_locked), .wr_valid(wr_valid),
  .wr_broadcast(wr_broadcast), .wr_cmd(wr_cmd), .wr_data(wr_data),
  .rd_cmd(rd_cmd), .rd_data(rd_data), .gc_reset(gc_reset));

// file: itp_ctl_model.sv
// Bus controller model driving SCL and the open-drain SDA
`timescale 1ns/100ps
module itp_ctl_model (
  // Bus wires
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  real qtr = 31.25;
  initial begin
    scl = 1'h1;
    sda_low = 1'h0;
  end
  // Start or repeated start, SCL left low
  task automatic start();
    #(qtr) sda_low = 1'h0;
    #(qtr) scl = 1'h1;
    #(qtr) sda_low = 1'h1;
    #(qtr) scl = 1'h0;
  endtask
  // SCL then stands still high
  task automatic stop();
    #(qtr) sda_low = 1'h1;
    #(qtr) scl = 1'h1;
    #(qtr) sda_low = 1'h0;
    #(qtr);
  endtask
  task automatic one_bit(input logic b, output logic s);
    #(qtr) sda_low = !b;
    #(qtr) scl = 1'h1;
    #(qtr) s = sda;
    #(qtr) scl = 1'h0;
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) one_bit(b[i], s);
    one_bit(1'h1, s);
    ack = !s;
  endtask
  task automatic recv_byte(input logic ack_it, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      one_bit(1'h1, s);
      d[i] = s;
    end
    one_bit(!ack_it, s);
  endtask
endmodule

// file: itp_target_tb_top.sv
// Testbench for the two-wire target register port
`timescale 1ns/100ps
module itp_target_tb_top;
  logic core_clk = 1'h0;
  logic rst = 1'h1;
  logic spi_seen = 1'h0;
  logic [15:0] rd_data = 16'h0000;
  logic [1:0] strap_sel = 2'h0;
  logic scl, sda_low, sda_out, sda_oe, i2c_locked;
  logic wr_valid, wr_broadcast, gc_reset;
  logic [7:0] wr_cmd, rd_cmd, d;
  logic [15:0] wr_data;
  logic [3:0] ak;
  int errors = 0, tests_run = 0, wr_cnt = 0, gc_cnt = 0, n;
  wire logic sda = !(sda_low || (sda_oe && !sda_out));
  wire logic strap = strap_sel[1] ? (strap_sel[0] ? scl : sda) :
    strap_sel[0];
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (wr_valid === 1'h1) wr_cnt++;
    if (gc_reset === 1'h1) gc_cnt++;
  end
  itp_ctl_model ctl (.sda(sda), .scl(scl), .sda_low(sda_low));
  itp_target DUT (.core_clk(core_clk), .rst(rst), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_strap_pin(strap), .spi_seen(spi_seen),
    .i2c_locked(i2c_locked), .wr_valid(wr_valid),
    .wr_broadcast(wr_broadcast), .wr_cmd(wr_cmd), .wr_data(wr_data),
    .rd_cmd(rd_cmd), .rd_data(rd_data), .gc_reset(gc_reset));
  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    $display("Checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic frame(logic [7:0] a, c, h, l, int nb);
    ak = 4'h0;
    ctl.start();
    ctl.send_byte(a, ak[3]);
    if (nb > 1) ctl.send_byte(c, ak[2]);
    if (nb > 2) ctl.send_byte(h, ak[1]);
    if (nb > 3) ctl.send_byte(l, ak[0]);
    ctl.stop();
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_write(logic [7:0] a, logic bc);
    n = wr_cnt;
    frame(a, 8'h3c, 8'ha5, 8'h5a, 4);
    chk("update acks", 16'hf, {12'h0, ak});
    chk("update count", 16'h1, 16'(wr_cnt - n));
    chk("update data", 16'ha55a, wr_data);
    chk("update cmd", 16'h3c, {8'h0, wr_cmd});
    chk("broadcast flag", {15'h0, bc}, {15'h0, wr_broadcast});
  endtask
  task automatic t_strap();
    for (int k = 0; k < 4; k++) begin
      strap_sel = 2'(k);
      frame({4'h9, 3'(k), 1'h0}, 8'h0, 8'h0, 8'h0, 1);
      chk("strap ack", 16'h8, {12'h0, ak});
      frame({4'h9, 3'(k ^ 1), 1'h0}, 8'h0, 8'h0, 8'h0, 1);
      chk("strap nack", 16'h0, {12'h0, ak});
    end
    strap_sel = 2'h0;
  endtask
  task automatic t_refuse();
    frame(8'h8f, 8'h0, 8'h0, 8'h0, 1);
    chk("broadcast read", 16'h0, {12'h0, ak});
    frame(8'hf0, 8'h0, 8'h0, 8'h0, 1);
    chk("ten-bit header", 16'h0, {12'h0, ak});
  endtask
  task automatic t_abort();
    n = wr_cnt;
    frame(8'h90, 8'h11, 8'h22, 8'h0, 3);
    chk("abort acks", 16'he, {12'h0, ak});
    chk("abort count", 16'h0, 16'(wr_cnt - n));
  endtask
  task automatic t_read();
    @(posedge core_clk) #1 rd_data = 16'hc3a9;
    ctl.start();
    ctl.send_byte(8'h90, ak[3]);
    ctl.send_byte(8'h21, ak[2]);
    ctl.start();
    ctl.send_byte(8'h91, ak[1]);
    ctl.recv_byte(1'h1, d);
    chk("read high", 16'hc3, {8'h0, d});
    ctl.recv_byte(1'h0, d);
    chk("read low", 16'ha9, {8'h0, d});
    ctl.stop();
    chk("read acks", 16'he, {12'h0, ak[3:1], 1'h0});
    chk("read cmd", 16'h21, {8'h0, rd_cmd});
  endtask
  task automatic t_gcall();
    n = gc_cnt;
    frame(8'h00, 8'h06, 8'h0, 8'h0, 2);
    chk("gcall acks", 16'hc, {12'h0, ak});
    chk("gcall pulse", 16'h1, 16'(gc_cnt - n));
    frame(8'h00, 8'h05, 8'h0, 8'h0, 2);
    chk("gcall other", 16'h8, {12'h0, ak});
    chk("gcall none", 16'h1, 16'(gc_cnt - n));
  endtask
  task automatic t_lock();
    chk("lock", 16'h1, {15'h0, i2c_locked});
    @(posedge core_clk) #1 spi_seen = 1'h1;
    @(posedge core_clk) #1 spi_seen = 1'h0;
    t_write(8'h90, 1'h0);
  endtask
  // Mid-run reset stands in for a power cycle; bus idles high meanwhile
  task automatic reset_dut();
    @(posedge core_clk) #1 rst = 1'h1;
    repeat (5) @(posedge core_clk);
    #1 rst = 1'h0;
    repeat (4) @(posedge core_clk);
    chk("reset data", 16'h0, wr_data);
    chk("reset cmd", 16'h0, {8'h0, rd_cmd});
    chk("reset lock", 16'h0, {15'h0, i2c_locked});
  endtask
  task automatic t_spi();
    reset_dut();
    n = wr_cnt;
    @(posedge core_clk) #1 spi_seen = 1'h1;
    @(posedge core_clk) #1 spi_seen = 1'h0;
    frame(8'h90, 8'h3c, 8'ha5, 8'h5a, 4);
    chk("spi mode acks", 16'h0, {12'h0, ak});
    chk("spi mode lock", 16'h0, {15'h0, i2c_locked});
    chk("spi mode count", 16'h0, 16'(wr_cnt - n));
    reset_dut();
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    #1 rst = 1'h0;
    repeat (4) @(posedge core_clk);
    t_write(8'h90, 1'h0);
    t_write(8'h8e, 1'h1);
    t_lock();
    t_spi();
    t_strap();
    t_refuse();
    t_abort();
    t_read();
    t_gcall();
    ctl.qtr = 625.0;
    t_write(8'h90, 1'h0);
    final_report();
  end
  initial begin
    repeat (100000) @(posedge core_clk);
    errors++;
    final_report();
  end
endmodule
